// File: src/binary_io_pkg.sv
package binary_io_pkg;

    // ****************
    // Widths and counts
    // ****************
    localparam int IN_CODE_W = 7;
    localparam int OUT_CODE_W = 6;
    localparam int DELAY_W = 14;
    localparam int INPUT5_ENTRIES = 3;
    localparam int OUTPUT_COUNT = 4;
    localparam int FREE_WORD_W = 16;
    localparam int MAIN_WORD_W = 16;
    localparam int OUT_SOURCE_COUNT = 36;

    // ****************
    // Input function codes
    // ****************
    localparam logic [6:0] FUNC_NONE = 7'h00;
    localparam logic [6:0] FUNC_RESERVED = 7'h01;
    localparam logic [6:0] FUNC_SHUTDOWN_BUTTON = 7'h02;
    localparam logic [6:0] FUNC_FAULT_ACK = 7'h05;
    localparam logic [6:0] FUNC_CRAWL_A = 7'h0F;
    localparam logic [6:0] FUNC_CRAWL_B = 7'h10;
    localparam logic [6:0] FUNC_EXT_FAULT = 7'h35;
    localparam logic [6:0] FUNC_SET_OUTPUT = 7'h3D;
    localparam logic [6:0] IN_FUNC_MAX = 7'h44;

    // ****************
    // Output function codes
    // ****************
    localparam logic [5:0] OUT_ZERO = 6'h00;
    localparam logic [5:0] OUT_ONE = 6'h01;
    localparam logic [5:0] OUT_SETTABLE = 6'h02;
    localparam logic [5:0] OUT_FAULT = 6'h03;
    localparam logic [5:0] OUT_FUNC_MAX = 6'h23;

    // ****************
    // Values after reset, factory values and delay limit
    // ****************
    localparam logic [6:0] INPUT5_DEFAULT = 7'h00;
    localparam logic [6:0] INPUT6_DEFAULT = 7'h05;
    localparam logic [6:0] FREE_WORD_DEFAULT = 7'h00;
    localparam logic [5:0] OUTPUT1_DEFAULT = 6'h03;
    localparam logic [5:0] OUTPUT_OTHER_DEFAULT = 6'h00;
    localparam logic [3:0] INVERT_DEFAULT = 4'h0;
    localparam logic [13:0] DELAY_DEFAULT = 14'h0000;
    localparam logic [13:0] DELAY_MAX_MS = 14'h2710;

    // ****************
    // Timing
    // ****************
    localparam int CLOCK_PERIOD_NS = 40;
    localparam int TICK_TIME_NS = 1000000;
    localparam int TICK_CYCLES = TICK_TIME_NS / CLOCK_PERIOD_NS;
    localparam int TICK_CNT_W = 16;

    typedef enum logic {
        MODE_LEVEL,
        MODE_EDGE
    } switch_mode_type;

endpackage : binary_io_pkg

// File: src/ms_tick_if.sv
`timescale 1ns/1ps
interface ms_tick_if;
    logic tick;

    modport source (output tick);
    modport sink (input tick);
endinterface : ms_tick_if

// File: src/ms_tick_gen.sv
`timescale 1ns/1ps
module ms_tick_gen
    import binary_io_pkg::*;
#(
    parameter int CYCLES = TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    ms_tick_if.source tick_port
);

    localparam logic [TICK_CNT_W-1:0] LAST = TICK_CNT_W'(CYCLES - 1);

    logic [TICK_CNT_W-1:0] count_reg;
    logic tick_reg;
    wire at_last = (count_reg == LAST);

    // ****************
    // Millisecond tick
    // ****************
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            count_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            count_reg <= at_last ? '0 : count_reg + 1'b1;
            tick_reg <= at_last;
        end
    end

    assign tick_port.tick = tick_reg;

endmodule : ms_tick_gen

// File: src/stable_filter.sv
`timescale 1ns/1ps
module stable_filter
    import binary_io_pkg::*;
#(
    parameter int WIDTH = DELAY_W
) (
    input wire logic core_clk,
    input wire logic reset,
    ms_tick_if.sink tick_port,
    input wire logic raw,
    input wire logic [WIDTH-1:0] delay_ms,
    output logic filtered
);

    logic [WIDTH-1:0] count_reg;
    logic level_reg;
    wire differs = (raw != level_reg);
    wire expired = (delay_ms == '0) || (count_reg > delay_ms);

    // ****************
    // Stability counter
    // ****************
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            count_reg <= '0;
            level_reg <= 1'b0;
        end else if (!differs) begin
            count_reg <= '0;
        end else if (expired) begin
            level_reg <= raw;
            count_reg <= '0;
        end else if (tick_port.tick) begin
            count_reg <= count_reg + 1'b1;
        end
    end

    assign filtered = level_reg;

endmodule : stable_filter

// File: src/binary_io_conditioning.sv
// Behaviour
// - Select input 5 holds three function entries at once.
// - All functions on one select input switch together from its level.
// - Input codes 0..68; 0 none, 1 reserved, others pick functions.
// - Select input 6 factory function is code 5, fault acknowledge.
// - External fault 53 raised only after its input stays low long enough.
// - Level mode: high commands switch-on or crawl, all three low commands shutdown.
// - Edge mode: rising edge on switch-on or crawl input starts it.
// - Edge mode: falling edge on shutdown button input commands shutdown.
// - Each of four select outputs has its own inversion bit, default 0.
// - Output source codes 0..35; 0 drives zero, 1 drives one.
// - Output code 2 is zero unless set by input function 61.
// - Each output changes only after source is stable for its delay.
`timescale 1ns/1ps
module binary_io_conditioning
    import binary_io_pkg::*;
#(
    parameter int TICK_LENGTH = TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic factory_settings,
    input wire logic input5_level,
    input wire logic input6_level,
    input wire logic switch_on_terminal,
    input wire logic [MAIN_WORD_W-1:0] main_control_word,
    input wire logic [FREE_WORD_W-1:0] free_control_word,
    input wire logic [INPUT5_ENTRIES-1:0][IN_CODE_W-1:0]
        input5_function_select,
    input wire logic [IN_CODE_W-1:0] input6_function_select,
    input wire logic [FREE_WORD_W-1:0][IN_CODE_W-1:0]
        free_word_function_select,
    input wire logic [DELAY_W-1:0] external_fault_delay,
    input wire logic switch_on_mode_control,
    input wire logic [OUTPUT_COUNT-1:0] output_invert_control,
    input wire logic [OUT_CODE_W-1:0] output1_function_select,
    input wire logic [OUT_CODE_W-1:0] output2_function_select,
    input wire logic [OUT_CODE_W-1:0] output3_function_select,
    input wire logic [OUT_CODE_W-1:0] output4_function_select,
    input wire logic [DELAY_W-1:0] output1_delay,
    input wire logic [DELAY_W-1:0] output2_delay,
    input wire logic [DELAY_W-1:0] output3_delay,
    input wire logic [DELAY_W-1:0] output4_delay,
    input wire logic fault_present,
    input wire logic [OUT_SOURCE_COUNT-1:0] output_function_sources,
    output logic switch_on_cmd,
    output logic crawl_a_cmd,
    output logic crawl_b_cmd,
    output logic shutdown_cmd,
    output logic fault_ack_cmd,
    output logic external_fault,
    output logic [OUTPUT_COUNT-1:0] select_output
);

    localparam int SRC_COUNT = INPUT5_ENTRIES + 1 + FREE_WORD_W;
    localparam int SRC_INPUT6 = INPUT5_ENTRIES;
    localparam int SRC_FREE = INPUT5_ENTRIES + 1;

    // ****************
    // Effective configuration
    // ****************
    logic [SRC_COUNT-1:0] src_level;
    logic [SRC_COUNT-1:0][IN_CODE_W-1:0] src_code;
    logic [OUTPUT_COUNT-1:0][OUT_CODE_W-1:0] out_code;
    logic [OUTPUT_COUNT-1:0][OUT_CODE_W-1:0] out_code_sel;
    logic [OUTPUT_COUNT-1:0][DELAY_W-1:0] out_delay_raw;
    logic [OUTPUT_COUNT-1:0][DELAY_W-1:0] out_delay;
    logic [DELAY_W-1:0] fault_delay;
    logic [OUTPUT_COUNT-1:0] invert_sel;
    wire switch_mode_type mode = switch_mode_type'(switch_on_mode_control);

    assign out_code_sel[0] = output1_function_select;
    assign out_code_sel[1] = output2_function_select;
    assign out_code_sel[2] = output3_function_select;
    assign out_code_sel[3] = output4_function_select;
    assign out_delay_raw[0] = output1_delay;
    assign out_delay_raw[1] = output2_delay;
    assign out_delay_raw[2] = output3_delay;
    assign out_delay_raw[3] = output4_delay;

    assign out_code[0] = factory_settings ? OUTPUT1_DEFAULT
                                          : out_code_sel[0];
    assign invert_sel = factory_settings ? INVERT_DEFAULT
                                         : output_invert_control;
    assign fault_delay = (external_fault_delay > DELAY_MAX_MS)
                       ? DELAY_MAX_MS : external_fault_delay;

    genvar gi;
    generate
        for (gi = 1; gi < OUTPUT_COUNT; gi++) begin : g_out_cfg
            assign out_code[gi] = factory_settings ? OUTPUT_OTHER_DEFAULT
                                                   : out_code_sel[gi];
        end
        for (gi = 0; gi < OUTPUT_COUNT; gi++) begin : g_out_delay
            assign out_delay[gi] = (out_delay_raw[gi] > DELAY_MAX_MS)
                                 ? DELAY_MAX_MS : out_delay_raw[gi];
        end
    endgenerate

    // ****************
    // Function sources
    // ****************
    generate
        for (gi = 0; gi < INPUT5_ENTRIES; gi++) begin : g_in5
            assign src_level[gi] = input5_level;
            assign src_code[gi] = factory_settings ? INPUT5_DEFAULT
                                  : input5_function_select[gi];
        end
        for (gi = 0; gi < FREE_WORD_W; gi++) begin : g_free
            assign src_level[SRC_FREE+gi] = free_control_word[gi];
            assign src_code[SRC_FREE+gi] = factory_settings
                ? FREE_WORD_DEFAULT : free_word_function_select[gi];
        end
    endgenerate

    assign src_level[SRC_INPUT6] = input6_level;
    assign src_code[SRC_INPUT6] = factory_settings ? INPUT6_DEFAULT
                                  : input6_function_select;

    // ****************
    // Function decode
    // ****************
    logic [SRC_COUNT-1:0] hit_ack;
    logic [SRC_COUNT-1:0] hit_crawl_a;
    logic [SRC_COUNT-1:0] hit_crawl_b;
    logic [SRC_COUNT-1:0] hit_set_out;
    logic [SRC_COUNT-1:0] low_ext_fault;
    logic [SRC_COUNT-1:0] low_shutdown;

    generate
        for (gi = 0; gi < SRC_COUNT; gi++) begin : g_decode
            wire valid = (src_code[gi] <= IN_FUNC_MAX)
                       && (src_code[gi] != FUNC_NONE)
                       && (src_code[gi] != FUNC_RESERVED);
            wire lvl = src_level[gi];
            wire [IN_CODE_W-1:0] c = src_code[gi];
            assign hit_ack[gi] = valid && (c == FUNC_FAULT_ACK) && lvl;
            assign hit_crawl_a[gi] = valid && (c == FUNC_CRAWL_A) && lvl;
            assign hit_crawl_b[gi] = valid && (c == FUNC_CRAWL_B) && lvl;
            assign hit_set_out[gi] = valid && (c == FUNC_SET_OUTPUT)
                                   && lvl;
            assign low_ext_fault[gi] = valid && (c == FUNC_EXT_FAULT)
                                     && !lvl;
            assign low_shutdown[gi] = valid && (c == FUNC_SHUTDOWN_BUTTON)
                                    && !lvl;
        end
    endgenerate

    wire ack_level = |hit_ack;
    wire crawl_a_level = |hit_crawl_a;
    wire crawl_b_level = |hit_crawl_b;
    wire set_out_level = |hit_set_out;
    wire ext_fault_low = |low_ext_fault;
    wire shutdown_low = |low_shutdown;
    wire switch_on_level = switch_on_terminal | main_control_word[0];

    // ****************
    // Millisecond tick and external fault qualification
    // ****************
    ms_tick_if tick_bus ();

    ms_tick_gen #(
        .CYCLES(TICK_LENGTH)
    ) u_tick (
        .core_clk(core_clk),
        .reset(reset),
        .tick_port(tick_bus)
    );

    logic ext_fault_qualified;

    stable_filter #(
        .WIDTH(DELAY_W)
    ) u_fault_filter (
        .core_clk(core_clk),
        .reset(reset),
        .tick_port(tick_bus),
        .raw(ext_fault_low),
        .delay_ms(fault_delay),
        .filtered(ext_fault_qualified)
    );

    logic external_fault_reg;
    logic fault_ack_reg;
    wire ext_fault_next = ext_fault_qualified
                        | (external_fault_reg & ~ack_level);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            external_fault_reg <= 1'b0;
            fault_ack_reg <= 1'b0;
        end else begin
            external_fault_reg <= ext_fault_next;
            fault_ack_reg <= ack_level;
        end
    end

    // ****************
    // Switch-on, crawl and shutdown
    // ****************
    logic switch_on_prev_reg;
    logic crawl_a_prev_reg;
    logic crawl_b_prev_reg;
    logic shutdown_prev_reg;
    logic switch_on_reg;
    logic crawl_a_reg;
    logic crawl_b_reg;
    logic shutdown_reg;

    wire rise_on = switch_on_level & ~switch_on_prev_reg;
    wire rise_crawl_a = crawl_a_level & ~crawl_a_prev_reg;
    wire rise_crawl_b = crawl_b_level & ~crawl_b_prev_reg;
    wire fall_shutdown = shutdown_low & ~shutdown_prev_reg;

    wire edge_on_next = rise_on | (switch_on_reg & ~fall_shutdown);
    wire edge_a_next = rise_crawl_a | (crawl_a_reg & ~fall_shutdown);
    wire edge_b_next = rise_crawl_b | (crawl_b_reg & ~fall_shutdown);

    logic on_next;
    logic a_next;
    logic b_next;
    logic sd_next;

    always_comb begin
        case (mode)
            MODE_LEVEL: begin
                on_next = switch_on_level;
                a_next = crawl_a_level;
                b_next = crawl_b_level;
                sd_next = ~(switch_on_level | crawl_a_level
                            | crawl_b_level);
            end
            default: begin
                on_next = edge_on_next;
                a_next = edge_a_next;
                b_next = edge_b_next;
                sd_next = fall_shutdown;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            switch_on_prev_reg <= 1'b0;
            crawl_a_prev_reg <= 1'b0;
            crawl_b_prev_reg <= 1'b0;
            shutdown_prev_reg <= 1'b0;
            switch_on_reg <= 1'b0;
            crawl_a_reg <= 1'b0;
            crawl_b_reg <= 1'b0;
            shutdown_reg <= 1'b0;
        end else begin
            switch_on_prev_reg <= switch_on_level;
            crawl_a_prev_reg <= crawl_a_level;
            crawl_b_prev_reg <= crawl_b_level;
            shutdown_prev_reg <= shutdown_low;
            switch_on_reg <= on_next;
            crawl_a_reg <= a_next;
            crawl_b_reg <= b_next;
            shutdown_reg <= sd_next;
        end
    end

    // ****************
    // Binary select outputs
    // ****************
    wire no_fault = ~(fault_present | external_fault_reg);
    logic [OUTPUT_COUNT-1:0] out_source;
    logic [OUTPUT_COUNT-1:0] out_stable;
    logic [OUTPUT_COUNT-1:0] select_output_reg;

    generate
        for (gi = 0; gi < OUTPUT_COUNT; gi++) begin : g_out
            wire [OUT_CODE_W-1:0] oc = out_code[gi];
            assign out_source[gi] =
                (oc == OUT_ZERO) ? 1'b0 :
                (oc == OUT_ONE) ? 1'b1 :
                (oc == OUT_SETTABLE) ? set_out_level :
                (oc == OUT_FAULT) ? no_fault :
                (oc <= OUT_FUNC_MAX) ? output_function_sources[oc] :
                1'b0;

            stable_filter #(
                .WIDTH(DELAY_W)
            ) u_out_filter (
                .core_clk(core_clk),
                .reset(reset),
                .tick_port(tick_bus),
                .raw(out_source[gi]),
                .delay_ms(out_delay[gi]),
                .filtered(out_stable[gi])
            );
        end
    endgenerate

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            select_output_reg <= '0;
        end else begin
            select_output_reg <= out_stable ^ invert_sel;
        end
    end

    // ****************
    // Outputs
    // ****************
    assign switch_on_cmd = switch_on_reg;
    assign crawl_a_cmd = crawl_a_reg;
    assign crawl_b_cmd = crawl_b_reg;
    assign shutdown_cmd = shutdown_reg;
    assign fault_ack_cmd = fault_ack_reg;
    assign external_fault = external_fault_reg;
    assign select_output = select_output_reg;

endmodule : binary_io_conditioning

// File: verification/binary_io_properties.sv
`timescale 1ns/1ps
module binary_io_properties
    import binary_io_pkg::*;
#(
    parameter int TICK_LENGTH = TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic factory_settings,
    input wire logic input5_level,
    input wire logic input6_level,
    input wire logic switch_on_terminal,
    input wire logic [MAIN_WORD_W-1:0] main_control_word,
    input wire logic [INPUT5_ENTRIES-1:0][IN_CODE_W-1:0]
        input5_function_select,
    input wire logic switch_on_mode_control,
    input wire logic [OUTPUT_COUNT-1:0] output_invert_control,
    input wire logic [OUT_CODE_W-1:0] output2_function_select,
    input wire logic [OUT_CODE_W-1:0] output4_function_select,
    input wire logic [DELAY_W-1:0] output1_delay,
    input wire logic [DELAY_W-1:0] output2_delay,
    input wire logic [DELAY_W-1:0] output4_delay,
    input wire logic fault_present,
    input wire logic [OUT_SOURCE_COUNT-1:0] output_function_sources,
    input wire logic switch_on_cmd,
    input wire logic crawl_a_cmd,
    input wire logic crawl_b_cmd,
    input wire logic shutdown_cmd,
    input wire logic fault_ack_cmd,
    input wire logic [OUTPUT_COUNT-1:0] select_output
);
    // ****************
    // Helper counters
    // ****************
    logic [1:0] live_reg;
    logic src4_reg;
    logic [15:0] calm_reg;
    wire logic live = live_reg == 2'h3;
    wire logic on_src = switch_on_terminal | main_control_word[0];
    wire logic mode = switch_on_mode_control;
    wire logic dly_cfg = !factory_settings && output4_delay == 14'h0002
        && output4_function_select == 6'h04;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            live_reg <= 2'h0;
            src4_reg <= 1'b0;
            calm_reg <= 16'h0000;
        end else begin
            live_reg <= live_reg + {1'b0, !live};
            src4_reg <= output_function_sources[4];
            calm_reg <= (!dly_cfg || output_function_sources[4] != src4_reg)
                ? 16'h0000 : calm_reg + {15'h0000, calm_reg != 16'hFFFF};
        end
    end

    // ****************
    // Properties
    // ****************
    level_follow_a: assert property (@(posedge core_clk)
        disable iff (reset) live && !$past(mode) && !$past(mode, 2)
        |-> switch_on_cmd == $past(on_src))
        else $error("switch-on does not follow level");
    edge_start_a: assert property (@(posedge core_clk)
        disable iff (reset) live && $past(mode) && $past(mode, 2)
        && $past(on_src) && !$past(on_src, 2) && !shutdown_cmd
        |-> switch_on_cmd)
        else $error("rising edge missed");
    shut_pulse_a: assert property (@(posedge core_clk)
        disable iff (reset) live && mode && $past(mode) && $past(mode, 2)
        && shutdown_cmd |=> !shutdown_cmd)
        else $error("shutdown pulse too long");
    multi_func_a: assert property (@(posedge core_clk)
        disable iff (reset) live && !$past(mode) && !$past(factory_settings)
        && $past(input5_level)
        && $past(input5_function_select[0]) == FUNC_CRAWL_A
        && $past(input5_function_select[2]) == FUNC_CRAWL_B
        |-> crawl_a_cmd && crawl_b_cmd)
        else $error("input 5 functions not switched together");
    ack_default_a: assert property (@(posedge core_clk)
        disable iff (reset) live && $past(factory_settings)
        && $past(input6_level) |-> fault_ack_cmd)
        else $error("default acknowledge missing");
    zero_invert_a: assert property (@(posedge core_clk)
        disable iff (reset) (!factory_settings && output2_delay == 14'h0000
        && output2_function_select == OUT_ZERO
        && output_invert_control[1])[*4] |-> select_output[1])
        else $error("inverted zero output wrong");
    fault_out_a: assert property (@(posedge core_clk)
        disable iff (reset) (factory_settings && fault_present
        && output1_delay == 14'h0000)[*4] |-> !select_output[0])
        else $error("fault output high on fault");
    delay_hold_a: assert property (@(posedge core_clk)
        disable iff (reset) live && dly_cfg && $changed(select_output[3])
        |-> calm_reg >= TICK_LENGTH)
        else $error("output changed before delay");
endmodule : binary_io_properties

bind binary_io_conditioning binary_io_properties #(
    .TICK_LENGTH(TICK_LENGTH)
) props (.core_clk, .reset, .factory_settings, .input5_level,
    .input6_level, .switch_on_terminal, .main_control_word,
    .input5_function_select, .switch_on_mode_control,
    .output_invert_control, .output2_function_select,
    .output4_function_select, .output1_delay, .output2_delay,
    .output4_delay, .fault_present, .output_function_sources,
    .switch_on_cmd, .crawl_a_cmd, .crawl_b_cmd, .shutdown_cmd,
    .fault_ack_cmd, .select_output);

// File: verification/field_terminals.sv
`timescale 1ns/1ps
module field_terminals (
    input wire logic core_clk,
    input wire logic [2:0] contact_req,
    input wire logic chatter,
    output logic input5_level,
    output logic input6_level,
    output logic switch_on_terminal
);
    // ****************
    // Contacts follow requests; chatter bounces input 6
    // ****************
    logic bounce_reg = 1'b0;
    always @(posedge core_clk) begin
        bounce_reg <= chatter & ~bounce_reg;
    end
    assign input5_level = contact_req[0];
    assign input6_level = contact_req[1] & ~bounce_reg;
    assign switch_on_terminal = contact_req[2];
endmodule : field_terminals

// File: verification/binary_io_conditioning_tb.sv
`timescale 1ns/1ps
module binary_io_conditioning_tb;
    import binary_io_pkg::*;
    localparam int TL = 10;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic factory_settings = 1'b0;
    logic [2:0] contact_req = 3'h0;
    logic chatter = 1'b0;
    logic input5_level, input6_level, switch_on_terminal;
    logic [15:0] main_control_word = 16'h0000;
    logic [15:0] free_control_word = 16'h0000;
    logic [2:0][6:0] input5_function_select = 21'h000000;
    logic [6:0] input6_function_select = 7'h00;
    logic [15:0][6:0] free_word_function_select = 112'h0;
    logic [13:0] external_fault_delay = 14'h0000;
    logic switch_on_mode_control = 1'b0;
    logic [3:0] output_invert_control = 4'h0;
    logic [3:0][5:0] out_sel = 24'h000000;
    logic [3:0][13:0] out_dly = 56'h0;
    logic fault_present = 1'b0;
    logic [35:0] output_function_sources = 36'h0;
    logic switch_on_cmd, crawl_a_cmd, crawl_b_cmd, shutdown_cmd;
    logic fault_ack_cmd, external_fault;
    logic [3:0] select_output;
    int fail_count = 0;
    int comparisons = 0;
    int seed = 32'h0B2E7372;
    int n;
    int r;
    int want;

    always #20 core_clk = ~core_clk;

    field_terminals terms (.core_clk, .contact_req, .chatter,
        .input5_level, .input6_level, .switch_on_terminal);

    binary_io_conditioning #(.TICK_LENGTH(TL)) DUT (.core_clk, .reset,
        .factory_settings, .input5_level, .input6_level,
        .switch_on_terminal, .main_control_word, .free_control_word,
        .input5_function_select, .input6_function_select,
        .free_word_function_select, .external_fault_delay,
        .switch_on_mode_control, .output_invert_control,
        .output1_function_select(out_sel[0]),
        .output2_function_select(out_sel[1]),
        .output3_function_select(out_sel[2]),
        .output4_function_select(out_sel[3]),
        .output1_delay(out_dly[0]), .output2_delay(out_dly[1]),
        .output3_delay(out_dly[2]), .output4_delay(out_dly[3]),
        .fault_present, .output_function_sources, .switch_on_cmd,
        .crawl_a_cmd, .crawl_b_cmd, .shutdown_cmd, .fault_ack_cmd,
        .external_fault, .select_output);

    // ****************
    // Tasks
    // ****************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic go(input int k);
        repeat (k) @(posedge core_clk);
    endtask : go
    task automatic look(input int k);
        go(k);
        @(negedge core_clk);
    endtask : look
    task automatic end_of_test;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    task automatic wait_fault(output int k);
        k = 0;
        while (external_fault !== 1'b1) begin
            @(negedge core_clk);
            k++;
            if (k > 100) begin
                fail_count++;
                end_of_test();
            end
        end
    endtask : wait_fault

    // ****************
    // Scenarios
    // ****************
    initial begin
        go(12);
        reset <= 1'b0;
        go(4);
        input5_function_select <= {FUNC_CRAWL_B, FUNC_FAULT_ACK, FUNC_CRAWL_A};
        free_word_function_select[5] <= FUNC_FAULT_ACK;
        for (n = 0; n < 12; n++) begin
            go(1);
            r = $random(seed);
            contact_req <= r[2:0];
            main_control_word <= {15'h0000, r[3]};
            free_control_word <= r[19:4];
            look(1);
            want = r & 1;
            check(crawl_a_cmd, want);
            check(crawl_b_cmd, want);
            check(fault_ack_cmd, (r | (r >> 9)) & 1);
            check(switch_on_cmd, ((r >> 2) | (r >> 3)) & 1);
        end
        go(1);
        input5_function_select <= {7'h45, FUNC_RESERVED, FUNC_NONE};
        free_control_word <= 16'h0000;
        contact_req <= 3'h1;
        look(1);
        check({crawl_a_cmd, crawl_b_cmd, fault_ack_cmd}, 0);
        $display("level test done");
        go(1);
        contact_req <= 3'h2;
        main_control_word <= 16'h0000;
        input5_function_select <= {FUNC_NONE, FUNC_NONE, FUNC_CRAWL_A};
        input6_function_select <= FUNC_SHUTDOWN_BUTTON;
        switch_on_mode_control <= 1'b1;
        go(4);
        contact_req <= 3'h3;
        look(1);
        check(crawl_a_cmd, 1);
        go(1);
        contact_req <= 3'h6;
        look(1);
        check(crawl_a_cmd, 1);
        check(switch_on_cmd, 1);
        go(1);
        contact_req <= 3'h0;
        look(1);
        check(shutdown_cmd, 1);
        check({crawl_a_cmd, switch_on_cmd}, 0);
        look(1);
        check(shutdown_cmd, 0);
        $display("edge test done");
        go(1);
        switch_on_mode_control <= 1'b0;
        input6_function_select <= FUNC_EXT_FAULT;
        input5_function_select <= {FUNC_NONE, FUNC_NONE, FUNC_FAULT_ACK};
        external_fault_delay <= 14'h0002;
        contact_req <= 3'h2;
        chatter <= 1'b1;
        look(3 * TL);
        check(external_fault, 0);
        go(1);
        chatter <= 1'b0;
        contact_req <= 3'h0;
        wait_fault(n);
        check(n >= 2 * TL, 1);
        check(n <= 3 * TL + 4, 1);
        go(1);
        contact_req <= 3'h3;
        look(40);
        check(external_fault, 0);
        $display("fault test done");
        go(1);
        contact_req <= 3'h2;
        factory_settings <= 1'b1;
        fault_present <= 1'b1;
        look(4);
        check(select_output[0], 0);
        go(1);
        fault_present <= 1'b0;
        look(4);
        check(select_output[0], 1);
        go(1);
        factory_settings <= 1'b0;
        out_sel <= {6'h04, OUT_SETTABLE, OUT_ZERO, OUT_ONE};
        output_invert_control <= 4'h2;
        out_dly <= {14'h0002, 14'h0000, 14'h0000, 14'h0000};
        input5_function_select <= {FUNC_NONE, FUNC_NONE, FUNC_SET_OUTPUT};
        look(4);
        check(select_output[0], 1);
        check(select_output[1], 1);
        check(select_output[2], 0);
        go(1);
        contact_req <= 3'h3;
        look(4);
        check(select_output[2], 1);
        for (n = 0; n < 6; n++) begin
            go(1);
            output_function_sources[4] <= ~output_function_sources[4];
        end
        look(3 * TL);
        check(select_output[3], 0);
        go(1);
        output_function_sources[4] <= 1'b1;
        look(2 * TL - 2);
        check(select_output[3], 0);
        look(TL + 6);
        check(select_output[3], 1);
        $display("output test done");
        end_of_test();
    end
endmodule : binary_io_conditioning_tb
